// file: core/ipg_core.sv
// Inverter PWM generator core: trip path, setup frames, grid tracking and drive outputs.
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Notes on behaviour
// R1: A debounced trip request latches the trip, forcing status and drives low.
// R2: The trip latch holds against every command until a reset cycle.
// R3: Trip request is registered on the clock and debounced before acting.
// R4: Trip status output is low while tripped, high otherwise.
// R5: Reset low forces every drive output low.
// R6: Reset low clears all counters, giving waveform phase zero.
// R7: Reset release leaves the trip clear; drives stay low until a control frame sets the inhibit bit high.
// R8: Running flag is high only while drives switch; low on reset, trip, inhibit.
// R9: Grid sync inputs come at half duty; used only in grid-tie mode.
// R10: Mode seven tracks measured grid frequency, running three percent slower.
// R11: Mode seven lets frequency fall after grid loss until an islanding stop.
// R12: Mode seven resumes switching by itself when the grid returns.
// R13: Third setup byte is dead time in carrier-derived units.
// R14: Host rounds fractional dead time upward.
// R15: Fourth setup byte is minimum pulse width; narrower pulses are suppressed.
// R16: Wave select value zero picks the sinusoid, the only shape.
// R17: Grid-voltage-present bit in fifth setup byte drives the grid_voltage_present output.
// R18: Frequency word is 13 bits spanning the range in 8192 steps.
// R19: Second control byte carries inhibit bit and upper frequency bits; one runs.
// R20: Samples are scaled by the amplitude byte, full scale 255.
// R21: Control frame is 05H, three bytes, checksum; loaded as one 24-bit word.
// R22: System routes trip status to a host interrupt input.
// R23: Inhibit low holds drives low while generation goes on; release is immediate.
// R24: Frequency word writes are ignored in modes 0, 1, 3, 4, 5 and 7.
// R25: Link rate selection starts at 9600 baud after every reset.
// R26: Each frame ends in an agreed checksum; mismatch answers the error code.
// R27: A latched trip keeps drives low whatever inhibit or register writes do.
// ************************************************************
module ipg_core #(
    parameter int GRID_LOSS_CYC = ipg_pkg::CLK_HZ / 1000 * ipg_pkg::GRID_LOSS_MS
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic trip_req,
    input wire logic [1:0] grid_sync_in,
    input wire logic [2:0] op_mode_pins,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_byte,
    output logic tx_valid,
    output logic [2:0] baud_sel,
    output logic grid_voltage_present,
    output logic trip_n,
    output logic outputs_running,
    output logic [3:0] drive
);
    // ********************************************************
    // Trip latch and start-up arming
    // ********************************************************
    logic trip_q_r, trip_r, trip_nxt;
    logic [2:0] deb_cnt_r, deb_cnt_nxt, arm_cnt_r, arm_cnt_nxt;
    logic armed;
    always_comb begin
        deb_cnt_nxt = trip_q_r ? 3'(deb_cnt_r + 3'h1) : 3'h0; // R3
        trip_nxt = trip_r | (trip_q_r && deb_cnt_r == 3'(ipg_pkg::TRIP_DEB_CYC - 1)); // R1 R2
        armed = arm_cnt_r == 3'(ipg_pkg::TRIP_DEB_CYC);
        arm_cnt_nxt = armed ? arm_cnt_r : 3'(arm_cnt_r + 3'h1);
    end
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            trip_q_r <= 1'b0;
            trip_r <= 1'b0; // R7
            deb_cnt_r <= 3'h0;
            arm_cnt_r <= 3'h0;
        end else begin
            trip_q_r <= trip_req; // R3
            trip_r <= trip_nxt;
            deb_cnt_r <= deb_cnt_nxt;
            arm_cnt_r <= arm_cnt_nxt;
        end
    end
    assign trip_n = ~trip_r; // R4

    // ********************************************************
    // Setup frame receiver and staging registers
    // ********************************************************
    ipg_pkg::ipg_rx_state_t st_r, st_nxt;
    logic [7:0] cmd_r, cmd_nxt, sum_r, sum_nxt, tx_byte_r, tx_byte_nxt, pdy_r, pdy_nxt;
    logic [7:0] pdt_r, pdt_nxt;
    logic [2:0] cnt_r, cnt_nxt, len, baud_r, baud_nxt;
    logic [47:0] buf_r, buf_nxt;
    logic [23:0] ctrl_r, ctrl_nxt;
    logic vg_r, vg_nxt, chk_good, ok;
    always_comb begin
        st_nxt = st_r;
        cmd_nxt = cmd_r;
        sum_nxt = sum_r;
        cnt_nxt = cnt_r;
        buf_nxt = buf_r;
        tx_byte_nxt = tx_byte_r;
        ctrl_nxt = ctrl_r;
        pdy_nxt = pdy_r;
        pdt_nxt = pdt_r;
        vg_nxt = vg_r;
        baud_nxt = baud_r;
        ok = 1'b0;
        chk_good = rx_byte == 8'(ipg_pkg::CHK_SEED - sum_r); // R26
        case (cmd_r)
            ipg_pkg::CMD_BAUD: len = ipg_pkg::LEN_BAUD;
            ipg_pkg::CMD_INIT: len = ipg_pkg::LEN_INIT;
            default: len = ipg_pkg::LEN_CTRL;
        endcase
        case (st_r)
            ipg_pkg::ST_IDLE: begin
                if (rx_valid && (rx_byte == ipg_pkg::CMD_BAUD || rx_byte == ipg_pkg::CMD_INIT
                        || rx_byte == ipg_pkg::CMD_CTRL)) begin
                    cmd_nxt = rx_byte;
                    sum_nxt = rx_byte;
                    cnt_nxt = 3'h0;
                    st_nxt = ipg_pkg::ST_DATA;
                end
            end
            ipg_pkg::ST_DATA: begin
                if (rx_valid) begin
                    buf_nxt = {buf_r[39:0], rx_byte};
                    sum_nxt = 8'(sum_r + rx_byte);
                    cnt_nxt = 3'(cnt_r + 3'h1);
                    if (cnt_r == 3'(len - 3'h1)) begin
                        st_nxt = ipg_pkg::ST_CHK;
                    end
                end
            end
            ipg_pkg::ST_CHK: begin
                if (rx_valid) begin
                    case (cmd_r)
                        ipg_pkg::CMD_BAUD: begin
                            ok = chk_good && buf_r[2:0] <= ipg_pkg::BAUD_MAX
                                && buf_r[7:3] == 5'h00;
                            if (ok) begin
                                baud_nxt = buf_r[2:0];
                            end
                        end
                        ipg_pkg::CMD_INIT: begin
                            ok = chk_good && buf_r[9 + ipg_pkg::INIT_WS_LSB -: 2]
                                == ipg_pkg::WS_SINE; // R16
                            if (ok) begin
                                pdy_nxt = buf_r[31:24]; // R13
                                pdt_nxt = buf_r[23:16]; // R15
                                vg_nxt = buf_r[8 + ipg_pkg::INIT_VG_BIT]; // R17
                            end
                        end
                        default: begin
                            ok = chk_good;
                            if (ok) begin
                                ctrl_nxt = {buf_r[7:0], buf_r[15:8], buf_r[23:16]}; // R21 R19 R20
                                if (!ipg_pkg::PFS_WR_MODES[op_mode_pins]) begin
                                    ctrl_nxt[ipg_pkg::PFS_W-1:0] =
                                        ctrl_r[ipg_pkg::PFS_W-1:0]; // R24
                                end
                            end
                        end
                    endcase
                    tx_byte_nxt = ok ? ipg_pkg::RSP_ACK : ipg_pkg::RSP_NAK; // R26
                    st_nxt = ipg_pkg::ST_RSP;
                end
            end
            ipg_pkg::ST_RSP: begin
                if (tx_ready) begin
                    tx_byte_nxt = 8'(ipg_pkg::CHK_SEED - tx_byte_r);
                    st_nxt = ipg_pkg::ST_RSPCHK;
                end
            end
            ipg_pkg::ST_RSPCHK: begin
                if (tx_ready) begin
                    st_nxt = ipg_pkg::ST_IDLE;
                end
            end
            default: st_nxt = ipg_pkg::ST_IDLE;
        endcase
    end
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st_r <= ipg_pkg::ST_IDLE;
            cmd_r <= 8'h00;
            sum_r <= 8'h00;
            cnt_r <= 3'h0;
            buf_r <= 48'h0;
            tx_byte_r <= 8'h00;
            ctrl_r <= ipg_pkg::CTRL_RST;
            pdy_r <= ipg_pkg::PDY_RST;
            pdt_r <= ipg_pkg::PDT_RST;
            vg_r <= ipg_pkg::VG_RST;
            baud_r <= ipg_pkg::BAUD_RST; // R25
        end else begin
            st_r <= st_nxt;
            cmd_r <= cmd_nxt;
            sum_r <= sum_nxt;
            cnt_r <= cnt_nxt;
            buf_r <= buf_nxt;
            tx_byte_r <= tx_byte_nxt;
            ctrl_r <= ctrl_nxt;
            pdy_r <= pdy_nxt;
            pdt_r <= pdt_nxt;
            vg_r <= vg_nxt;
            baud_r <= baud_nxt;
        end
    end
    assign tx_byte = tx_byte_r;
    assign tx_valid = st_r == ipg_pkg::ST_RSP || st_r == ipg_pkg::ST_RSPCHK;
    assign baud_sel = baud_r;
    assign grid_voltage_present = vg_r;

    // ********************************************************
    // Grid tracking, anti-islanding and waveform phase
    // ********************************************************
    logic auto, grid_ok, grid_edge, island_r, island_nxt, step, tick;
    logic [1:0] gs_q_r;
    logic gs_prev_r;
    logic [20:0] gper_r, gper_nxt;
    logic [15:0] iv_r, iv_nxt, base_r, base_nxt, ivc_r, ivc_nxt;
    logic [6:0] sidx_r, sidx_nxt, idx;
    logic [ipg_pkg::PH_W-1:0] phase_r, phase_nxt;
    always_comb begin
        auto = op_mode_pins == ipg_pkg::MODE_GRID_AUTO;
        grid_edge = auto && gs_q_r[0] && !gs_prev_r && !gs_q_r[1]; // R9
        grid_ok = gper_r < 21'(GRID_LOSS_CYC);
        gper_nxt = grid_edge ? 21'h0 : (grid_ok ? 21'(gper_r + 21'h1) : gper_r);
        step = ivc_r >= iv_r;
        ivc_nxt = step ? 16'h0 : 16'(ivc_r + 16'h1);
        sidx_nxt = step ? 7'(sidx_r + 7'h1) : sidx_r;
        iv_nxt = iv_r;
        base_nxt = base_r;
        island_nxt = island_r;
        if (grid_edge && grid_ok) begin
            iv_nxt = 16'((22'(gper_r) + 22'(gper_r >> ipg_pkg::PER_SHIFT)) >> 7); // R10
            base_nxt = iv_nxt;
            island_nxt = 1'b0; // R12
        end else if (!grid_ok && !island_r) begin
            if (step && sidx_r == 7'h7f) begin
                iv_nxt = 16'(iv_r + (iv_r >> ipg_pkg::DRIFT_SHIFT)); // R11
            end
            island_nxt = 17'(iv_r) > 17'(base_r) + 17'(base_r >> ipg_pkg::ISL_SHIFT); // R11
        end
        phase_nxt = tick ? ipg_pkg::PH_W'(phase_r + ipg_pkg::PH_W'(ctrl_r[ipg_pkg::PFS_W-1:0]))
            : phase_r; // R18
        idx = auto ? sidx_r : phase_r[ipg_pkg::PH_W-1 -: 7];
    end
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            gs_q_r <= 2'h0;
            gs_prev_r <= 1'b0;
            gper_r <= 21'h0; // R6
            iv_r <= 16'h0;
            base_r <= 16'h0;
            ivc_r <= 16'h0;
            sidx_r <= 7'h0;
            phase_r <= '0;
            island_r <= 1'b1;
        end else begin
            gs_q_r <= grid_sync_in;
            gs_prev_r <= gs_q_r[0];
            gper_r <= gper_nxt;
            iv_r <= iv_nxt;
            base_r <= base_nxt;
            ivc_r <= ivc_nxt;
            sidx_r <= sidx_nxt;
            phase_r <= phase_nxt;
            island_r <= island_nxt;
        end
    end

    // ********************************************************
    // Carrier, sampling and amplitude scaling
    // ********************************************************
    logic [2:0] div_r, div_nxt;
    logic [7:0] carr_r, carr_nxt, ref_r, ref_nxt;
    logic up_r, up_nxt;
    logic signed [7:0] sample;
    logic signed [16:0] prod;
    ipg_sine_rom u_rom (
        .clock(clock),
        .rst_b(rst_b),
        .idx(idx),
        .sample(sample)
    );
    always_comb begin
        tick = div_r == 3'(ipg_pkg::CARR_DIV_CYC - 1);
        div_nxt = tick ? 3'h0 : 3'(div_r + 3'h1);
        up_nxt = up_r;
        carr_nxt = carr_r;
        if (tick) begin
            if (up_r ? carr_r == 8'hff : carr_r == 8'h00) begin
                up_nxt = !up_r;
            end else begin
                carr_nxt = up_r ? 8'(carr_r + 8'h1) : 8'(carr_r - 8'h1);
            end
        end
        prod = sample * $signed({1'b0, ctrl_r[ipg_pkg::CTL_AMP_LSB +: 8]}); // R20
        ref_nxt = (tick && (carr_r == 8'h00 || carr_r == 8'hff)) ? (prod[15:8] ^ 8'h80) : ref_r;
    end
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            div_r <= 3'h0;
            carr_r <= 8'h00;
            up_r <= 1'b1;
            ref_r <= 8'h80;
        end else begin
            div_r <= div_nxt;
            carr_r <= carr_nxt;
            up_r <= up_nxt;
            ref_r <= ref_nxt;
        end
    end

    // ********************************************************
    // Per-leg dead time, pulse deletion and output gating
    // ********************************************************
    wire logic [1:0] leg_top, leg_bot;
    logic run, running_r;
    logic [3:0] drive_r, drive_nxt;
    for (genvar g = 0; g < 2; g++) begin : g_leg
        logic cur_r, cur_nxt, want;
        logic [7:0] dead_r, dead_nxt, hold_r, hold_nxt;
        always_comb begin
            want = (g == 0 ? ref_r : ~ref_r) > carr_r;
            cur_nxt = cur_r;
            dead_nxt = dead_r;
            hold_nxt = hold_r;
            if (tick) begin
                dead_nxt = dead_r == 8'h00 ? 8'h00 : 8'(dead_r - 8'h1);
                hold_nxt = hold_r == 8'h00 ? 8'h00 : 8'(hold_r - 8'h1);
                if (want != cur_r && hold_r == 8'h00) begin
                    cur_nxt = want;
                    dead_nxt = pdy_r; // R13
                    hold_nxt = pdt_r; // R15
                end
            end
        end
        always_ff @(posedge clock) begin
            if (!rst_b) begin
                cur_r <= 1'b0;
                dead_r <= 8'h00;
                hold_r <= 8'h00;
            end else begin
                cur_r <= cur_nxt;
                dead_r <= dead_nxt;
                hold_r <= hold_nxt;
            end
        end
        assign leg_top[g] = cur_r && dead_r == 8'h00;
        assign leg_bot[g] = !cur_r && dead_r == 8'h00;
    end
    always_comb begin
        run = armed && !trip_r && ctrl_r[ipg_pkg::CTL_INH_BIT] && !(auto && island_r); // R23 R27 R11
        drive_nxt = run ? {leg_top[1], leg_bot[1], leg_top[0], leg_bot[0]} : 4'h0; // R1 R27
    end
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            drive_r <= 4'h0; // R5
            running_r <= 1'b0;
        end else begin
            drive_r <= drive_nxt;
            running_r <= run; // R8
        end
    end
    assign drive = drive_r;
    assign outputs_running = running_r;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge clock); endclocking
    sequence s_trip_held;
        trip_req [*5];
    endsequence
    sequence s_ctrl_frame;
        st_r == ipg_pkg::ST_CHK && cmd_r == ipg_pkg::CMD_CTRL && rx_valid && chk_good;
    endsequence
    property p_trip_debounce;
        disable iff (!rst_b) s_trip_held |=> !trip_n;
    endproperty
    a_trip_debounce: assert property (p_trip_debounce) else $error("trip not latched"); // R3
    property p_trip_sticky;
        disable iff (!rst_b) !trip_n |=> !trip_n [*3];
    endproperty
    a_trip_sticky: assert property (p_trip_sticky) else $error("trip latch cleared"); // R2
    property p_trip_drive;
        disable iff (!rst_b) !trip_n |=> drive == 4'h0 && !outputs_running;
    endproperty
    a_trip_drive: assert property (p_trip_drive) else $error("drive on while tripped"); // R1
    property p_trip_cause;
        disable iff (!rst_b) $fell(trip_n) |-> $past(trip_q_r, 1) && $past(trip_req, 5);
    endproperty
    a_trip_cause: assert property (p_trip_cause) else $error("trip without request"); // R4
    property p_reset_clear;
        !rst_b |=> drive == 4'h0 && !outputs_running && phase_r == '0 && sidx_r == 7'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left state"); // R5
    property p_reset_release;
        $rose(rst_b) |-> trip_n && baud_sel == ipg_pkg::BAUD_RST;
    endproperty
    a_reset_release: assert property (p_reset_release) else $error("bad state at release"); // R7
    property p_running;
        disable iff (!rst_b) outputs_running |-> $past(trip_n && ctrl_r[ipg_pkg::CTL_INH_BIT]);
    endproperty
    a_running: assert property (p_running) else $error("running flag wrong"); // R8
    property p_inhibit;
        disable iff (!rst_b) !ctrl_r[ipg_pkg::CTL_INH_BIT] |=> drive == 4'h0;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("drive on while inhibited"); // R23
    property p_island;
        disable iff (!rst_b) auto && island_r |=> drive == 4'h0;
    endproperty
    a_island: assert property (p_island) else $error("drive on while islanded"); // R11
    property p_pfs_ro;
        disable iff (!rst_b)
            $changed(ctrl_r[ipg_pkg::PFS_W-1:0]) |-> $past(ipg_pkg::PFS_WR_MODES[op_mode_pins]);
    endproperty
    a_pfs_ro: assert property (p_pfs_ro) else $error("frequency word written"); // R24
    property p_ctrl_load;
        disable iff (!rst_b) s_ctrl_frame |=>
            ctrl_r[23:13] == {$past(buf_r[7:0]), $past(buf_r[15:13])}
            && tx_valid && tx_byte == ipg_pkg::RSP_ACK;
    endproperty
    a_ctrl_load: assert property (p_ctrl_load) else $error("control word not loaded"); // R21
endmodule : ipg_core
`default_nettype wire

// file: core/ipg_sine_rom.sv
// Quarter-wave sinusoid table with registered signed sample output.
`timescale 1ns/1ps
`default_nettype none
module ipg_sine_rom (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [6:0] idx,
    output logic signed [7:0] sample
);
    localparam logic [7:0] TBL [32] = '{
        8'h03, 8'h09, 8'h10, 8'h16, 8'h1c, 8'h22, 8'h28, 8'h2e,
        8'h33, 8'h39, 8'h3f, 8'h44, 8'h49, 8'h4e, 8'h53, 8'h58,
        8'h5c, 8'h60, 8'h64, 8'h68, 8'h6b, 8'h6f, 8'h71, 8'h74,
        8'h76, 8'h79, 8'h7a, 8'h7c, 8'h7d, 8'h7e, 8'h7f, 8'h7f};
    logic [4:0] addr;
    logic signed [7:0] sample_nxt;
    // Mirror the quarter for the second half of each half cycle, negate the second half.
    always_comb begin
        addr = idx[5] ? ~idx[4:0] : idx[4:0];
        sample_nxt = idx[6] ? -$signed(TBL[addr]) : $signed(TBL[addr]);
    end
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sample <= 8'sh00;
        end else begin
            sample <= sample_nxt;
        end
    end
endmodule : ipg_sine_rom
`default_nettype wire

// file: pkg/ipg_pkg.sv
// Shared constants and types of the inverter PWM generator.
package ipg_pkg;
    // ********************************************************
    // Clock and timing
    // ********************************************************
    localparam int CLK_HZ = 40000000;
    localparam int CLK_NS = 25;
    localparam int TRIP_DEB_NS = 100;
    localparam int TRIP_DEB_CYC = (TRIP_DEB_NS + CLK_NS - 1) / CLK_NS;
    localparam int CARR_DIV_CYC = 4;
    localparam int GRID_LOSS_MS = 40;
    localparam int PH_W = 24;
    localparam int DRIFT_SHIFT = 4;
    localparam int ISL_SHIFT = 2;
    localparam int PER_SHIFT = 5;
    // ********************************************************
    // Frame codes
    // ********************************************************
    localparam logic [7:0] CMD_BAUD = 8'h02;
    localparam logic [7:0] CMD_INIT = 8'h04;
    localparam logic [7:0] CMD_CTRL = 8'h05;
    localparam logic [7:0] RSP_ACK = 8'h00;
    localparam logic [7:0] RSP_NAK = 8'hff;
    localparam logic [7:0] CHK_SEED = 8'hf1;
    localparam logic [2:0] LEN_BAUD = 3'h1;
    localparam logic [2:0] LEN_INIT = 3'h6;
    localparam logic [2:0] LEN_CTRL = 3'h3;
    // ********************************************************
    // Fields and reset values
    // ********************************************************
    localparam logic [2:0] BAUD_RST = 3'h0;
    localparam logic [2:0] BAUD_MAX = 3'h6;
    localparam logic [2:0] MODE_GRID_AUTO = 3'h7;
    localparam logic [7:0] PFS_WR_MODES = 8'h44;
    localparam int PFS_W = 13;
    localparam int CTL_INH_BIT = 13;
    localparam int CTL_AMP_LSB = 16;
    localparam int INIT_WS_LSB = 0;
    localparam int INIT_VG_BIT = 3;
    localparam logic [1:0] WS_SINE = 2'h0;
    localparam logic [23:0] CTRL_RST = 24'h000000;
    localparam logic [7:0] PDY_RST = 8'h0d;
    localparam logic [7:0] PDT_RST = 8'h1a;
    localparam logic VG_RST = 1'b0;
    // ********************************************************
    // Frame receiver states
    // ********************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DATA = 3'h1,
        ST_CHK = 3'h2,
        ST_RSP = 3'h3,
        ST_RSPCHK = 3'h4
    } ipg_rx_state_t;
endpackage : ipg_pkg

// file: testbench/inverter_pwm_trip_and_setup_bench.sv
// Self-checking bench of the inverter PWM generator core.
`timescale 1ns/1ps
`default_nettype none
module inverter_pwm_trip_and_setup_bench;
    logic clock, rst_b, trip_req, slow, grid_on, rx_valid, tx_ready, tx_valid, gvp, trip_n, run;
    logic [1:0] grid_sync_in;
    logic [2:0] op_mode_pins, baud_sel;
    logic [3:0] drive;
    logic [7:0] rx_byte, tx_byte, b0, amplitude_word;
    logic [10:0] gcnt;
    logic [7:0] exp_q[$];
    int n_mismatch, n_tests, cyc;
    ipg_core #(.GRID_LOSS_CYC(3000)) dut (.clock(clock), .rst_b(rst_b), .trip_req(trip_req),
        .grid_sync_in(grid_sync_in), .op_mode_pins(op_mode_pins), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid),
        .baud_sel(baud_sel), .grid_voltage_present(gvp), .trip_n(trip_n),
        .outputs_running(run), .drive(drive));
    ipg_host_model host (.clock(clock), .tx_valid(tx_valid), .slow(slow), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .tx_ready(tx_ready));
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic cmp_flag(input string nm, input logic e, input logic g);
        cmp(nm, {7'h0, e}, {7'h0, g});
    endtask : cmp_flag
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic frame(input logic [7:0] f[$], input logic bad, input logic [7:0] code);
        exp_q.push_back(code);
        exp_q.push_back(8'hf1 - code);
        host.send(f, bad);
        while (exp_q.size() != 0) @(negedge clock);
        repeat (8) @(negedge clock);
    endtask : frame
    // ****************************
    // Clock, grid pulses, monitor
    // ****************************
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(negedge clock) begin
        gcnt <= gcnt + 11'h001;
        grid_sync_in <= grid_on ? {~gcnt[10], gcnt[10]} : 2'h0;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            cmp("reply", exp_q.pop_front(), tx_byte);
        end
        if ((drive[0] & drive[1]) | (drive[2] & drive[3])) cmp("leg", 8'h0, {4'h0, drive});
        if (cyc == 60000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(98977));
        {rst_b, trip_req, slow, grid_on, gcnt, n_mismatch, n_tests, cyc} = '0;
        op_mode_pins = 3'h2;
        repeat (6) @(negedge clock);
        cmp("drive", 8'h0, {4'h0, drive});
        cmp_flag("run", 1'b0, run);
        rst_b = 1'b1;
        repeat (2) @(negedge clock);
        cmp_flag("trip_n", 1'b1, trip_n);
        cmp("baud_sel", 8'h0, {5'h0, baud_sel});
        cmp_flag("gvp", 1'b0, gvp);
        b0 = 8'($urandom);
        amplitude_word = 8'($urandom);
        for (int i = 0; i < 3; i++) begin
            frame('{8'h05, b0, (i == 1) ? 8'h00 : 8'h3f, amplitude_word}, 1'b0, 8'h00);
            cmp_flag("run", i != 1, run);
            if (i == 1) cmp("drive", 8'h0, {4'h0, drive});
        end
        frame('{8'h05, b0, 8'h00, amplitude_word}, 1'b1, 8'hff);
        cmp_flag("run", 1'b1, run);
        frame('{8'h04, 8'h00, 8'h48, 8'h34, 8'h67, 8'h08, 8'h00}, 1'b0, 8'h00);
        cmp_flag("gvp", 1'b1, gvp);
        for (int w = 1; w < 4; w++) begin
            frame('{8'h04, 8'h0, 8'h48, 8'h34, 8'h67, 8'(w), 8'h0}, 1'b0, 8'hff);
        end
        cmp_flag("gvp", 1'b1, gvp);
        slow = 1'b1;
        for (int k = 0; k < 9; k++) begin
            b0 = (k == 8) ? 8'($urandom_range(6)) : 8'(k);
            frame('{8'h02, b0}, 1'b0, (k == 7) ? 8'hff : 8'h00);
            cmp("baud_sel", (k == 7) ? 8'h6 : b0, {5'h0, baud_sel});
        end
        slow = 1'b0;
        trip_req = 1'b1;
        repeat (3) @(negedge clock);
        trip_req = 1'b0;
        repeat (10) @(negedge clock);
        cmp_flag("trip_n", 1'b1, trip_n);
        trip_req = 1'b1;
        repeat (4) @(negedge clock);
        cmp_flag("trip_n", 1'b1, trip_n);
        @(negedge clock);
        cmp_flag("trip_n", 1'b0, trip_n);
        @(negedge clock);
        cmp("drive", 8'h0, {4'h0, drive});
        cmp_flag("run", 1'b0, run);
        trip_req = 1'b0;
        frame('{8'h05, b0, 8'h20, amplitude_word}, 1'b0, 8'h00);
        cmp_flag("run", 1'b0, run);
        cmp_flag("trip_n", 1'b0, trip_n);
        rst_b = 1'b0;
        op_mode_pins = 3'h7;
        repeat (6) @(negedge clock);
        rst_b = 1'b1;
        repeat (2) @(negedge clock);
        cmp_flag("trip_n", 1'b1, trip_n);
        frame('{8'h05, 8'h5a, 8'h20, 8'hcc}, 1'b0, 8'h00);
        cmp_flag("run", 1'b0, run);
        for (int g = 0; g < 3; g++) begin
            grid_on = (g != 1);
            repeat ((g == 1) ? 20000 : 5000) @(negedge clock);
            cmp_flag("run", g != 1, run);
        end
        tally_and_finish();
    end
endmodule : inverter_pwm_trip_and_setup_bench
`default_nettype wire

// file: testbench/ipg_host_model.sv
// Host model that sends setup frames and takes the replies.
`timescale 1ns/1ps
`default_nettype none
module ipg_host_model (
    input wire logic clock,
    input wire logic tx_valid,
    input wire logic slow,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic tx_ready
);
    logic [1:0] stall;
    initial begin
        rx_byte = 8'h5a;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
        stall = 2'h0;
    end
    // Replies are taken at once, or one cycle in four when slow.
    always @(negedge clock) begin
        stall <= stall + 2'h1;
        tx_ready <= !slow || (stall == 2'h3);
    end
    task automatic send(input logic [7:0] frm[$], input logic bad);
        logic [7:0] chk;
        chk = 8'hf1;
        while (tx_valid !== 1'b0) @(negedge clock);
        foreach (frm[i]) begin
            @(negedge clock);
            rx_byte = frm[i];
            rx_valid = 1'b1;
            chk = chk - frm[i];
        end
        @(negedge clock);
        rx_byte = chk + {7'h0, bad};
        @(negedge clock);
        rx_valid = 1'b0;
        rx_byte = ~rx_byte;
    endtask : send
endmodule : ipg_host_model
`default_nettype wire
